/* File: rtl/pcnt_sfr_host.sv */
// Processor-side controller: AXI4-Lite orders turned into register accesses
`timescale 1ns/1ps
`default_nettype none
`include "pcnt_params.svh"

module pcnt_sfr_host
	import pcnt_pkg::*;
(
	input wire logic clk_sys_in, // System clock
	input wire logic resetn_in, // Asynchronous reset, active low
	pcnt_sfr_if.host sfr, // Register bus to the counter block
	input wire logic [7:0] s_axi_awaddr_in, // Write address
	input wire logic s_axi_awvalid_in, // Write address valid
	output logic s_axi_awready_out, // Write address ready
	input wire logic [31:0] s_axi_wdata_in, // Write data
	input wire logic [3:0] s_axi_wstrb_in, // Write byte enables
	input wire logic s_axi_wvalid_in, // Write data valid
	output logic s_axi_wready_out, // Write data ready
	output logic [1:0] s_axi_bresp_out, // Write response
	output logic s_axi_bvalid_out, // Write response valid
	input wire logic s_axi_bready_in, // Write response ready
	input wire logic [7:0] s_axi_araddr_in, // Read address
	input wire logic s_axi_arvalid_in, // Read address valid
	output logic s_axi_arready_out, // Read address ready
	output logic [31:0] s_axi_rdata_out, // Read data
	output logic [1:0] s_axi_rresp_out, // Read response
	output logic s_axi_rvalid_out, // Read valid
	input wire logic s_axi_rready_in, // Read ready
	output logic irq_out // Level interrupt
);

	// ----------------------------------------------------------------
	// AXI4-Lite write path
	// ----------------------------------------------------------------
	logic aw_have_q, w_have_q, bvalid_q, wr_go;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q;
	host_state_t state_q;
	sfr_byte_t page_q, addr_q, wbyte_q, rbyte_q;
	logic dir_wr_q, start_w;
	logic [`HOST_INT_W-1:0] int_q, mask_q, int_set, int_clr;

	assign wr_go = aw_have_q && w_have_q && !bvalid_q;
	assign s_axi_awready_out = !aw_have_q;
	assign s_axi_wready_out = !w_have_q;

	// Address and data are caught independently, in either order
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid_in && !aw_have_q)
			begin
				aw_have_q <= 1'b1;
				awaddr_q <= s_axi_awaddr_in;
			end
			else if (wr_go)
				aw_have_q <= 1'b0;
			if (s_axi_wvalid_in && !w_have_q)
			begin
				w_have_q <= 1'b1;
				wdata_q <= s_axi_wdata_in;
				wstrb_q <= s_axi_wstrb_in;
			end
			else if (wr_go)
				w_have_q <= 1'b0;
		end
	end

	// Response one cycle after both halves are in; unmapped gets SLVERR
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			bvalid_q <= 1'b0;
			bresp_q <= `AXI_RESP_OKAY;
		end
		else if (wr_go)
		begin
			bvalid_q <= 1'b1;
			case (awaddr_q)
				`HOST_CTRL, `HOST_ADDR, `HOST_WDATA, `HOST_RDATA, `HOST_STATUS,
				`HOST_INT_STATUS, `HOST_INT_MASK: bresp_q <= `AXI_RESP_OKAY;
				default: bresp_q <= `AXI_RESP_SLVERR;
			endcase
		end
		else if (s_axi_bready_in)
			bvalid_q <= 1'b0;
	end
	assign s_axi_bvalid_out = bvalid_q;
	assign s_axi_bresp_out = bresp_q;

	// Order registers; a start while busy is dropped
	assign start_w = wr_go && (awaddr_q == `HOST_CTRL) && wstrb_q[0]
		&& wdata_q[`HOST_CTRL_START] && (state_q == HOST_IDLE);
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			page_q <= 8'h00;
			addr_q <= 8'h00;
			wbyte_q <= 8'h00;
			mask_q <= '0;
			dir_wr_q <= 1'b0;
		end
		else if (wr_go)
		begin
			if (awaddr_q == `HOST_ADDR && wstrb_q[0])
				addr_q <= wdata_q[7:0];
			if (awaddr_q == `HOST_ADDR && wstrb_q[1])
				page_q <= wdata_q[15:8];
			if (awaddr_q == `HOST_WDATA && wstrb_q[0])
				wbyte_q <= wdata_q[7:0];
			if (awaddr_q == `HOST_INT_MASK && wstrb_q[0])
				mask_q <= wdata_q[`HOST_INT_W-1:0];
			if (start_w)
				dir_wr_q <= wdata_q[`HOST_CTRL_WRITE];
		end
	end

	// ----------------------------------------------------------------
	// Register-bus sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			state_q <= HOST_IDLE;
			rbyte_q <= 8'h00;
		end
		else
		begin
			case (state_q)
				HOST_IDLE: if (start_w) state_q <= HOST_ISSUE;
				HOST_ISSUE: state_q <= dir_wr_q ? HOST_IDLE : HOST_WAIT;
				HOST_WAIT:
					if (sfr.rack)
					begin
						rbyte_q <= sfr.rdata;
						state_q <= HOST_IDLE;
					end
				default: state_q <= HOST_IDLE;
			endcase
		end
	end
	assign sfr.page = page_q;
	assign sfr.addr = addr_q;
	assign sfr.wdata = wbyte_q;
	assign sfr.wr = (state_q == HOST_ISSUE) && dir_wr_q;
	assign sfr.rd = (state_q == HOST_ISSUE) && !dir_wr_q;

	// ----------------------------------------------------------------
	// Interrupts: sticky, write-one-to-clear, set beats clear
	// ----------------------------------------------------------------
	assign int_set = {sfr.match_b, sfr.match_a,
		((state_q == HOST_ISSUE) && dir_wr_q) || ((state_q == HOST_WAIT) && sfr.rack)};
	assign int_clr = (wr_go && awaddr_q == `HOST_INT_STATUS && wstrb_q[0])
		? wdata_q[`HOST_INT_W-1:0] : '0;
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			int_q <= '0;
		else
			int_q <= (int_q & ~int_clr) | int_set;
	end
	assign irq_out = |(int_q & mask_q);

	// ----------------------------------------------------------------
	// AXI4-Lite read path
	// ----------------------------------------------------------------
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	assign s_axi_arready_out = !rvalid_q;
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `AXI_RESP_OKAY;
		end
		else if (s_axi_arvalid_in && !rvalid_q)
		begin
			rvalid_q <= 1'b1;
			rresp_q <= `AXI_RESP_OKAY;
			case (s_axi_araddr_in)
				`HOST_CTRL: rdata_q <= {30'h0000_0000, dir_wr_q, 1'b0};
				`HOST_ADDR: rdata_q <= {16'h0000, page_q, addr_q};
				`HOST_WDATA: rdata_q <= {24'h00_0000, wbyte_q};
				`HOST_RDATA: rdata_q <= {24'h00_0000, rbyte_q};
				`HOST_STATUS: rdata_q <= {31'h0000_0000, state_q != HOST_IDLE};
				`HOST_INT_STATUS: rdata_q <= {29'h0000_0000, int_q};
				`HOST_INT_MASK: rdata_q <= {29'h0000_0000, mask_q};
				default:
				begin
					rdata_q <= 32'h0000_0000;
					rresp_q <= `AXI_RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready_in)
			rvalid_q <= 1'b0;
	end
	assign s_axi_rvalid_out = rvalid_q;
	assign s_axi_rdata_out = rdata_q;
	assign s_axi_rresp_out = rresp_q;

endmodule
`default_nettype wire

/* File: rtl/pcnt_params.svh */
// Constants of the pulse counter register block and its host-side controller
//
// How it works
// - Low byte read snapshots the middle and high bytes
// - Software reads low byte before middle, high
// - Counter low byte: read-only, zero reset, bits 7:0
// - Compare value 0: three RW bytes, zero reset
// - Software writes compare 0 low byte last
// - Compare 0 low write commits within two ticks
// - Compare value 1: three RW bytes, zero reset
// - Software writes compare 1 low byte last
// - Compare 1 low write commits within two ticks
// - Read-only history shifts one direction per count
// - History bit: 1 clockwise, 0 counter-clockwise
// - Software may read 0x55/0xAA as flutter
// - Registers decode only on page 0x2
// - Flag match when counter 0 equals compare 0
// - Flag match when counter 1 equals compare 1
`ifndef PCNT_PARAMS_SVH
`define PCNT_PARAMS_SVH

// ----------------------------------------------------------------
// Register side of the counter block
// ----------------------------------------------------------------
`define PCNT_SFR_PAGE 8'h02
`define PCNT_COUNT_B_LO 8'hdd
`define PCNT_COUNT_B_MID 8'hde
`define PCNT_COUNT_B_HI 8'hdf
`define PCNT_MATCH_A_LO 8'he1
`define PCNT_MATCH_A_MID 8'he2
`define PCNT_MATCH_A_HI 8'he3
`define PCNT_MATCH_B_LO 8'hf1
`define PCNT_MATCH_B_MID 8'hf2
`define PCNT_MATCH_B_HI 8'hf3
`define PCNT_HISTORY 8'hf4
`define PCNT_BYTE_RESET 8'h00
`define PCNT_VAL_RESET 24'h00_0000
`define PCNT_HIST_W 8
`define PCNT_SYNC_TICKS 2

// ----------------------------------------------------------------
// Controller registers on AXI4-Lite
// ----------------------------------------------------------------
`define HOST_CTRL 8'h00
`define HOST_ADDR 8'h04
`define HOST_WDATA 8'h08
`define HOST_RDATA 8'h0c
`define HOST_STATUS 8'h10
`define HOST_INT_STATUS 8'h14
`define HOST_INT_MASK 8'h18
`define HOST_CTRL_START 0
`define HOST_CTRL_WRITE 1
`define HOST_INT_DONE 0
`define HOST_INT_MATCH_A 1
`define HOST_INT_MATCH_B 2
`define HOST_INT_W 3
`define AXI_RESP_OKAY 2'b00
`define AXI_RESP_SLVERR 2'b10

`endif

/* File: rtl/pcnt_pkg.sv */
// Types shared by the counter register block and its controller
package pcnt_pkg;
	typedef logic [7:0] sfr_byte_t;
	typedef logic [23:0] match_val_t;
	typedef enum logic [2:0]
	{
		HOST_IDLE = 3'b001,
		HOST_ISSUE = 3'b010,
		HOST_WAIT = 3'b100
	} host_state_t;
endpackage

/* File: rtl/pcnt_sfr_if.sv */
// Register bus between the processor-side controller and the counter block
`timescale 1ns/1ps
`default_nettype none
interface pcnt_sfr_if;
	logic [7:0] page; // Page select
	logic [7:0] addr; // Register address
	logic wr; // Write strobe, one cycle
	logic rd; // Read strobe, one cycle
	logic [7:0] wdata; // Write data
	logic [7:0] rdata; // Read data, valid with rack
	logic rack; // Read answer, one cycle after rd
	logic match_a; // Compare 0 match pulse
	logic match_b; // Compare 1 match pulse
	modport device
	(
		input page, addr, wr, rd, wdata,
		output rdata, rack, match_a, match_b
	);
	modport host
	(
		output page, addr, wr, rd, wdata,
		input rdata, rack, match_a, match_b
	);
endinterface
`default_nettype wire

/* File: rtl/pcnt_regs_dev.sv */
// Pulse counter register block: counter 1 readback, compare values, history
`timescale 1ns/1ps
`default_nettype none
`include "pcnt_params.svh"

module pcnt_regs_dev
	import pcnt_pkg::*;
#(
	parameter int HIST_W = `PCNT_HIST_W,
	parameter int SYNC_TICKS = `PCNT_SYNC_TICKS
)
(
	input wire logic clk_sys_in, // System clock
	input wire logic resetn_in, // Asynchronous reset, active low
	pcnt_sfr_if.device sfr, // Register bus from the core
	input wire logic [23:0] count_a_in, // Counter 0 value
	input wire logic [23:0] count_b_in, // Counter 1 value
	input wire logic count_step_in, // One pulse per recorded count
	input wire logic count_cw_in, // Direction of that count, 1 clockwise
	input wire logic rtc_tick_in, // One pulse per counter-domain clock
	output logic [23:0] match_a_value_out, // Active compare value 0
	output logic [23:0] match_b_value_out, // Active compare value 1
	output logic match_a_flag_out, // Counter 0 match pulse
	output logic match_b_flag_out, // Counter 1 match pulse
	output logic [HIST_W-1:0] history_out // Direction history
);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	localparam int TICK_W = $clog2(SYNC_TICKS + 1);
	localparam logic [TICK_W-1:0] TICK_LOAD = TICK_W'(SYNC_TICKS);
	localparam logic [TICK_W-1:0] TICK_ONE = TICK_W'(1);
	localparam logic [TICK_W-1:0] TICK_ZERO = '0;

	logic page_ok;
	logic wr_ok;
	logic rd_ok;
	logic [1:0][23:0] count_w;
	logic [1:0][23:0] active_w;
	logic [1:0][2:0][7:0] byte_w;
	logic [1:0] flag_w;
	logic [15:0] snap_q;
	logic [HIST_W-1:0] hist_q;
	sfr_byte_t rdata_q;
	logic rack_q;

	// Every access outside the block's page is ignored by decode
	assign page_ok = (sfr.page == `PCNT_SFR_PAGE);
	assign wr_ok = sfr.wr && page_ok;
	assign rd_ok = sfr.rd && page_ok;

	// Counter 0 is compared with value 0, counter 1 with value 1
	assign count_w[0] = count_a_in;
	assign count_w[1] = count_b_in;

	// ----------------------------------------------------------------
	// Compare channels
	// ----------------------------------------------------------------
	for (genvar g = 0; g < 2; g++)
	begin : ch
		localparam sfr_byte_t ADDR_LO = (g == 0) ? `PCNT_MATCH_A_LO : `PCNT_MATCH_B_LO;
		localparam sfr_byte_t ADDR_MID = (g == 0) ? `PCNT_MATCH_A_MID : `PCNT_MATCH_B_MID;
		localparam sfr_byte_t ADDR_HI = (g == 0) ? `PCNT_MATCH_A_HI : `PCNT_MATCH_B_HI;

		sfr_byte_t lo_q;
		sfr_byte_t mid_q;
		sfr_byte_t hi_q;
		match_val_t xfer_q;
		match_val_t active_q;
		logic [TICK_W-1:0] pend_q;
		logic eq_q;
		logic flag_q;
		logic commit_w;

		assign commit_w = wr_ok && (sfr.addr == ADDR_LO);

		// Byte registers keep exactly what software wrote, for readback
		always_ff @(posedge clk_sys_in or negedge resetn_in)
		begin
			if (!resetn_in)
			begin
				lo_q <= `PCNT_BYTE_RESET;
				mid_q <= `PCNT_BYTE_RESET;
				hi_q <= `PCNT_BYTE_RESET;
			end
			else if (wr_ok)
			begin
				case (sfr.addr)
					ADDR_LO: lo_q <= sfr.wdata;
					ADDR_MID: mid_q <= sfr.wdata;
					ADDR_HI: hi_q <= sfr.wdata;
					default: lo_q <= lo_q;
				endcase
			end
		end

		// Low-byte write freezes the new value and starts the crossing.
		// The frozen copy keeps later high/middle writes out of this commit.
		always_ff @(posedge clk_sys_in or negedge resetn_in)
		begin
			if (!resetn_in)
			begin
				xfer_q <= `PCNT_VAL_RESET;
				pend_q <= TICK_ZERO;
			end
			else if (commit_w)
			begin
				xfer_q <= {hi_q, mid_q, sfr.wdata};
				pend_q <= TICK_LOAD;
			end
			else if (rtc_tick_in && (pend_q != TICK_ZERO))
			begin
				pend_q <= pend_q - TICK_ONE;
			end
		end

		// Active value moves on the last counter-domain tick of the crossing
		always_ff @(posedge clk_sys_in or negedge resetn_in)
		begin
			if (!resetn_in)
			begin
				active_q <= `PCNT_VAL_RESET;
			end
			else if (!commit_w && rtc_tick_in && (pend_q == TICK_ONE))
			begin
				active_q <= xfer_q;
			end
		end

		// Match flag is a pulse on the start of equality, so a counter
		// resting on the value does not flood the flag logic.
		// eq_q resets high: the all-zero state after reset is not a match event.
		always_ff @(posedge clk_sys_in or negedge resetn_in)
		begin
			if (!resetn_in)
			begin
				eq_q <= 1'b1;
				flag_q <= 1'b0;
			end
			else
			begin
				eq_q <= (count_w[g] == active_q);
				flag_q <= (count_w[g] == active_q) && !eq_q;
			end
		end

		assign active_w[g] = active_q;
		assign byte_w[g][0] = lo_q;
		assign byte_w[g][1] = mid_q;
		assign byte_w[g][2] = hi_q;
		assign flag_w[g] = flag_q;
	end

	// ----------------------------------------------------------------
	// Counter 1 snapshot and direction history
	// ----------------------------------------------------------------
	// Reading the low byte freezes the upper bytes, so the three reads
	// form one value even while the counter keeps moving
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			snap_q <= 16'h0000;
		end
		else if (rd_ok && (sfr.addr == `PCNT_COUNT_B_LO))
		begin
			snap_q <= count_b_in[23:8];
		end
	end

	// Newest direction enters at bit 0; oldest falls off the top
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			hist_q <= '0;
		end
		else if (count_step_in)
		begin
			hist_q <= {hist_q[HIST_W-2:0], count_cw_in};
		end
	end

	// ----------------------------------------------------------------
	// Read answer
	// ----------------------------------------------------------------
	// Every read gets an answer one cycle later; undecoded ones read zero,
	// so the core never waits on a missing register
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			rack_q <= 1'b0;
			rdata_q <= `PCNT_BYTE_RESET;
		end
		else
		begin
			rack_q <= sfr.rd;
			if (sfr.rd)
			begin
				if (!page_ok)
				begin
					rdata_q <= `PCNT_BYTE_RESET;
				end
				else
				begin
					case (sfr.addr)
						`PCNT_COUNT_B_LO: rdata_q <= count_b_in[7:0];
						`PCNT_COUNT_B_MID: rdata_q <= snap_q[7:0];
						`PCNT_COUNT_B_HI: rdata_q <= snap_q[15:8];
						`PCNT_MATCH_A_LO: rdata_q <= byte_w[0][0];
						`PCNT_MATCH_A_MID: rdata_q <= byte_w[0][1];
						`PCNT_MATCH_A_HI: rdata_q <= byte_w[0][2];
						`PCNT_MATCH_B_LO: rdata_q <= byte_w[1][0];
						`PCNT_MATCH_B_MID: rdata_q <= byte_w[1][1];
						`PCNT_MATCH_B_HI: rdata_q <= byte_w[1][2];
						`PCNT_HISTORY: rdata_q <= hist_q[7:0];
						default: rdata_q <= `PCNT_BYTE_RESET;
					endcase
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign sfr.rdata = rdata_q;
	assign sfr.rack = rack_q;
	assign sfr.match_a = flag_w[0];
	assign sfr.match_b = flag_w[1];
	assign match_a_value_out = active_w[0];
	assign match_b_value_out = active_w[1];
	assign match_a_flag_out = flag_w[0];
	assign match_b_flag_out = flag_w[1];
	assign history_out = hist_q;

endmodule
`default_nettype wire

/* File: test/pcnt_sfr_checker.sv */
// Concurrent checks on the register bus between controller and counter block
`timescale 1ns/1ps
`default_nettype none
module pcnt_sfr_checker
(
	input wire logic clk_sys_in, // System clock
	input wire logic resetn_in, // Reset, active low
	input wire logic [7:0] page, // Page select
	input wire logic [7:0] addr, // Register address
	input wire logic wr, // Write strobe
	input wire logic rd, // Read strobe
	input wire logic [7:0] wdata, // Write data
	input wire logic [7:0] rdata, // Read data
	input wire logic rack, // Read answer
	input wire logic match_a, // Match pulse 0
	input wire logic match_b // Match pulse 1
);
	logic [7:0] hi_a_q;
	logic [7:0] hi_b_q;
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!resetn_in);
	// ----------------------------------------------------------------
	// Shadow of the staged high bytes
	// ----------------------------------------------------------------
	// Only decoded-page writes count, so stray pages show up as mismatches
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			hi_a_q <= 8'h00;
			hi_b_q <= 8'h00;
		end
		else if (wr && page == 8'h02)
		begin
			if (addr == 8'he3)
				hi_a_q <= wdata;
			if (addr == 8'hf3)
				hi_b_q <= wdata;
		end
	end
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	a_read_answered:
	assert property (rd |=> rack) else $error("Read not answered next cycle");
	a_rack_needs_read:
	assert property (!rd |=> !rack) else $error("Read answer without read");
	a_rdata_holds:
	assert property (!rd |=> $stable(rdata)) else $error("Read data moved");
	a_page_decode:
	assert property (rd && page != 8'h02 |=> rdata == 8'h00) else $error("Other page answered");
	a_stage_a_readback:
	assert property (rd && page == 8'h02 && addr == 8'he3 |=> rdata == hi_a_q)
		else $error("Compare 0 high byte readback wrong");
	a_stage_b_readback:
	assert property (rd && page == 8'h02 && addr == 8'hf3 |=> rdata == hi_b_q)
		else $error("Compare 1 high byte readback wrong");
	a_strobes_apart:
	assert property (!(wr && rd) ##1 !(wr && rd)) else $error("Write and read together");
	a_match_a_pulse:
	assert property ($rose(match_a) |=> !match_a) else $error("Match 0 pulse too long");
	a_match_b_pulse:
	assert property (match_b |=> !match_b) else $error("Match 1 pulse too long");
endmodule
`default_nettype wire

/* File: test/pulse_counter_compare_regs_tb_top.sv */
// Self-checking bench: controller and counter block joined over the register bus
`timescale 1ns/1ps
`default_nettype none
`include "pcnt_params.svh"
module pulse_counter_compare_regs_tb_top;
	import pcnt_pkg::*;
	logic clk_sys_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq, flag_a, flag_b;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [23:0] cnt_a = 24'h00_0000, cnt_b = 24'h00_0000, mval_a, mval_b;
	logic step = 1'b0, cw = 1'b0, tick = 1'b0;
	logic [7:0] hist;
	int fail_count = 0, cmp_count = 0, seed = 2036, ev_cnt = 0;
	logic [33:0] exp_q[$];
	logic [1:0] bexp_q[$];
	pcnt_sfr_if bus();
	pcnt_sfr_host i_pcnt_sfr_host (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .sfr(bus),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .irq_out(irq));
	pcnt_regs_dev i_pcnt_regs_dev (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .sfr(bus),
		.count_a_in(cnt_a), .count_b_in(cnt_b), .count_step_in(step), .count_cw_in(cw),
		.rtc_tick_in(tick), .match_a_value_out(mval_a), .match_b_value_out(mval_b),
		.match_a_flag_out(flag_a), .match_b_flag_out(flag_b), .history_out(hist));
	pcnt_sfr_checker i_pcnt_sfr_checker (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
		.page(bus.page), .addr(bus.addr), .wr(bus.wr), .rd(bus.rd), .wdata(bus.wdata),
		.rdata(bus.rdata), .rack(bus.rack), .match_a(bus.match_a), .match_b(bus.match_b));
	// ----------------------------------------------------------------
	// Clock, bus event count and result monitor
	// ----------------------------------------------------------------
	always #5 clk_sys_in = ~clk_sys_in;
	// Counting strobes lets a task wait on the bus without racing the AXI answer
	always @(posedge clk_sys_in)
		if (bus.wr === 1'b1 || bus.rack === 1'b1)
			ev_cnt <= ev_cnt + 1;
	// Every read result is matched against the oldest note
	always @(posedge clk_sys_in)
		if (rvalid === 1'b1 && rready)
			check({rresp, rdata}, exp_q.pop_front());
	// Every write response is matched against the oldest write note
	always @(posedge clk_sys_in)
		if (bvalid === 1'b1 && bready)
			check(34'(bresp), 34'(bexp_q.pop_front()));
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		$display("Compares %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------
	// Address and data offered together, each released once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		// Every offset up to the interrupt mask register is expected to answer OKAY, higher ones SLVERR
		bexp_q.push_back((a > `HOST_INT_MASK) ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY);
		@(posedge clk_sys_in);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk_sys_in);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end
		while (!(bvalid && bready));
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [33:0] exp);
		@(posedge clk_sys_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		exp_q.push_back(exp);
		do
		begin
			@(posedge clk_sys_in);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end
		while (!(rvalid && rready));
		rready <= 1'b0;
	endtask
	// One register access through the controller, waiting for its strobe
	task automatic sfr(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] d,
		input logic w);
		int n;
		n = ev_cnt;
		axi_wr(`HOST_ADDR, {16'h0000, pg, a});
		if (w)
			axi_wr(`HOST_WDATA, {24'h00_0000, d});
		axi_wr(`HOST_CTRL, {30'h0000_0000, w, 1'b1});
		for (int i = 0; i < 50 && ev_cnt == n; i++)
			@(posedge clk_sys_in);
		repeat (2) @(posedge clk_sys_in);
	endtask
	task automatic sfr_rd(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] e);
		sfr(pg, a, 8'h00, 1'b0);
		axi_rd(`HOST_RDATA, {`AXI_RESP_OKAY, 24'h00_0000, e});
	endtask
	task automatic tick_pulse;
		@(posedge clk_sys_in);
		tick <= 1'b1;
		@(posedge clk_sys_in);
		tick <= 1'b0;
		#1;
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial
	begin
		logic [23:0] v, ma, mb;
		logic [7:0] base, hx;
		logic c;
		logic [7:0] regs[8];
		regs = '{8'hdd, 8'he1, 8'he2, 8'he3, 8'hf1, 8'hf2, 8'hf3, 8'hf4};
		repeat (6) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		foreach (regs[i])
			sfr_rd(8'h02, regs[i], 8'h00);
		$display("Test reset values done");
		// Staged bytes stay inactive until the low byte and two ticks
		for (int k = 0; k < 2; k++)
		begin
			v = 24'($random(seed));
			base = k ? 8'hf1 : 8'he1;
			sfr(8'h02, base + 8'h02, v[23:16], 1'b1);
			sfr(8'h02, base + 8'h01, v[15:8], 1'b1);
			check(34'(k ? mval_b : mval_a), 34'h0_0000_0000);
			sfr(8'h02, base, v[7:0], 1'b1);
			tick_pulse();
			check(34'(k ? mval_b : mval_a), 34'h0_0000_0000);
			tick_pulse();
			check(34'(k ? mval_b : mval_a), 34'(v));
			sfr_rd(8'h02, base + 8'h02, v[23:16]);
			sfr_rd(8'h02, base + 8'h01, v[15:8]);
			sfr_rd(8'h02, base, v[7:0]);
			if (k)
				mb = v;
			else
				ma = v;
		end
		$display("Test compare commit done");
		sfr(8'h03, 8'he3, ~ma[23:16], 1'b1);
		sfr_rd(8'h02, 8'he3, ma[23:16]);
		sfr_rd(8'h03, 8'he3, 8'h00);
		$display("Test page decode done");
		// Counter moves between the low read and the upper reads
		v = 24'($random(seed));
		cnt_b <= v;
		sfr_rd(8'h02, 8'hdd, v[7:0]);
		cnt_b <= ~v;
		sfr_rd(8'h02, 8'hde, v[15:8]);
		sfr_rd(8'h02, 8'hdf, v[23:16]);
		sfr(8'h02, 8'hf4, 8'hff, 1'b1);
		sfr_rd(8'h02, 8'hf4, 8'h00);
		$display("Test counter snapshot done");
		// Back-to-back counts with random direction
		hx = 8'h00;
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clk_sys_in);
			c = 1'($random(seed));
			step <= 1'b1;
			cw <= c;
			hx = {hx[6:0], c};
		end
		@(posedge clk_sys_in);
		step <= 1'b0;
		#1;
		check(34'(hist), 34'(hx));
		sfr_rd(8'h02, 8'hf4, hx);
		// Eight alternating counts leave the flutter pattern software looks for
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk_sys_in);
			step <= 1'b1;
			cw <= i[0];
		end
		@(posedge clk_sys_in);
		step <= 1'b0;
		#1;
		check(34'(hist), 34'h0_0000_0055);
		sfr_rd(8'h02, 8'hf4, 8'h55);
		$display("Test history done");
		// Match events, sticky status, mask and clear
		axi_wr(`HOST_INT_STATUS, 32'h0000_0007);
		axi_rd(`HOST_INT_STATUS, {`AXI_RESP_OKAY, 32'h0000_0000});
		cnt_a <= ma;
		@(posedge clk_sys_in);
		#1;
		check(34'(flag_a), 34'h0_0000_0001);
		repeat (3) @(posedge clk_sys_in);
		axi_rd(`HOST_INT_STATUS, {`AXI_RESP_OKAY, 32'h0000_0002});
		check(34'(irq), 34'h0_0000_0000);
		axi_wr(`HOST_INT_MASK, 32'h0000_0006);
		repeat (2) @(posedge clk_sys_in);
		check(34'(irq), 34'h0_0000_0001);
		cnt_b <= mb;
		@(posedge clk_sys_in);
		#1;
		check(34'(flag_b), 34'h0_0000_0001);
		repeat (3) @(posedge clk_sys_in);
		axi_rd(`HOST_INT_STATUS, {`AXI_RESP_OKAY, 32'h0000_0006});
		axi_wr(`HOST_INT_STATUS, 32'h0000_0006);
		axi_rd(`HOST_INT_STATUS, {`AXI_RESP_OKAY, 32'h0000_0000});
		repeat (2) @(posedge clk_sys_in);
		check(34'(irq), 34'h0_0000_0000);
		axi_wr(8'h1c, 32'h0000_0001);
		axi_rd(8'h1c, {`AXI_RESP_SLVERR, 32'h0000_0000});
		$display("Test match interrupt done");
		stop_test();
	end
	// Watchdog well beyond the several hundred cycles the run needs
	initial
	begin
		repeat (20000) @(posedge clk_sys_in);
		fail_count++;
		stop_test();
	end
endmodule
`default_nettype wire
